//--- core/lnkctl_pkg.sv
// package: register map, field positions, resets and carrier types for the link control block
package lnkctl_pkg;
	localparam logic [11:0] LINK_CONTROL_OFFSET  = 12'h07C;
	localparam logic [15:0] LINK_CONTROL_RESET   = 16'h0000;
	localparam int          EXT_SYNC_BIT         = 7;
	localparam int          SHARED_REFCLK_BIT    = 6;
	localparam int          RETRAIN_BIT          = 5;
	localparam int          LINK_OFF_BIT         = 4;
	localparam int          BOUNDARY_BIT         = 3;
	localparam int          APM_LSB              = 0;
	localparam logic [15:0] LINK_CONTROL_WR_MASK = 16'h00D3;
	localparam logic [15:0] FTS_EXT_COUNT        = 16'h1000;
	localparam logic [15:0] FTS_NORMAL_COUNT     = 16'h0000;
	localparam logic [15:0] TS1_EXT_COUNT        = 16'h0400;
	localparam logic [15:0] TS1_NORMAL_COUNT     = 16'h0000;
	localparam logic [2:0]  EXIT_LAT_MAX         = 3'h7;
	localparam logic [7:0]  PORT_LOW_ID          = 8'h02;

	typedef enum logic [1:0] {
		LNKCTL_APM_DISABLED,
		LNKCTL_APM_L0S,
		LNKCTL_APM_RESERVED,
		LNKCTL_APM_L0S_L1
	} lnkctl_apm_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  device;
		logic [2:0]  function_num;
		logic [11:0] offset;
		logic [3:0]  byteEnable;
		logic [31:0] writeData;
	} lnkctl_cfg_req_t;

	typedef struct packed {
		logic        extSync;
		logic        sharedRefclk;
		logic        linkOff;
		lnkctl_apm_t apmCtrl;
	} lnkctl_ctrl_t;

	typedef struct packed {
		logic [15:0] ftsCount;
		logic        skpAfterFts;
		logic [15:0] ts1Count;
		logic [2:0]  l0sExitLat;
		logic [2:0]  l1ExitLat;
	} lnkctl_train_t;
endpackage

//--- core/lnkctl_latency.sv
// exit latency and ordered-set counts derived from control settings
`timescale 1ns/100ps
module lnkctl_latency #(
	parameter logic [2:0] L0S_LAT_ASYNC  = 3'h7,
	parameter logic [2:0] L0S_LAT_COMMON = 3'h7,
	parameter logic [2:0] L1_LAT_ASYNC   = 3'h7,
	parameter logic [2:0] L1_LAT_COMMON  = 3'h7
) (
	input  wire logic                    extSync,
	input  wire logic                    sharedRefclk,
	output lnkctl_pkg::lnkctl_train_t    train
);
	import lnkctl_pkg::*;

	always_comb begin
		train.ftsCount    = extSync ? FTS_EXT_COUNT : FTS_NORMAL_COUNT;
		train.skpAfterFts = extSync;
		train.ts1Count    = extSync ? TS1_EXT_COUNT : TS1_NORMAL_COUNT;
		train.l0sExitLat  = sharedRefclk ? L0S_LAT_COMMON : L0S_LAT_ASYNC;
		train.l1ExitLat   = sharedRefclk ? L1_LAT_COMMON : L1_LAT_ASYNC;
	end
endmodule

//--- core/lnkctl_regs.sv
// link control register for one root port with config-space access
`timescale 1ns/100ps
module lnkctl_regs #(
	parameter logic [7:0] PORT_DEVICE    = 8'h02,
	parameter logic       COMBINED_UPPER = 1'b0
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire lnkctl_pkg::lnkctl_cfg_req_t cfgReq,
	input  wire logic                    combineActive,
	output      logic                    cfgReadValid,
	output      logic [31:0]             cfgReadData,
	output      lnkctl_pkg::lnkctl_ctrl_t    ctrl,
	output      logic                    retrainStart,
	output      lnkctl_pkg::lnkctl_train_t   train
);
	import lnkctl_pkg::*;

	// stored controls; retrain, boundary and reserved bits have no storage
	logic          extSyncBit;
	logic          sharedRefclkBit;
	logic          linkOffBit;
	logic [1:0]    apmField;
	logic [15:0]   linkControl;
	logic          hit;
	logic          readHit;
	logic          writeLow;
	logic [15:0]   readView;
	lnkctl_train_t next_train;
	// registered copies handed to the link logic
	logic          ctrlExtSync;
	logic          ctrlSharedRefclk;
	logic          ctrlLinkOff;
	lnkctl_apm_t   ctrlApm;
	logic [15:0]   trainFts;
	logic          trainSkp;
	logic [15:0]   trainTs1;
	logic [2:0]    trainL0sLat;
	logic [2:0]    trainL1Lat;

	function automatic logic [15:0] lnkctl_view(input logic [15:0] stored);
		lnkctl_view = stored & LINK_CONTROL_WR_MASK;
	endfunction

	// request aimed at this register of this port
	function automatic logic lnkctl_decode(
		input lnkctl_cfg_req_t req,
		input logic [7:0]      device,
		input logic            stepAside
	);
		lnkctl_decode = req.valid && req.device == device && req.function_num == 3'h0
			&& req.offset == LINK_CONTROL_OFFSET && !stepAside;
	endfunction

	// byte lane 0 carries every writable bit
	function automatic logic lnkctl_lane_write(
		input lnkctl_cfg_req_t req,
		input logic            sel
	);
		lnkctl_lane_write = sel && req.write && req.byteEnable[0];
	endfunction

	// upper port of a combined pair steps aside
	always_comb begin
		hit      = lnkctl_decode(cfgReq, PORT_DEVICE, COMBINED_UPPER && combineActive);
		readHit  = hit && !cfgReq.write;
		writeLow = lnkctl_lane_write(cfgReq, hit);
		readView = lnkctl_view(linkControl);
	end

	// image of the register; unstored bits sit at their reset level
	always_comb begin
		linkControl                    = LINK_CONTROL_RESET;
		linkControl[EXT_SYNC_BIT]      = extSyncBit;
		linkControl[SHARED_REFCLK_BIT] = sharedRefclkBit;
		linkControl[LINK_OFF_BIT]      = linkOffBit;
		linkControl[APM_LSB +: 2]      = apmField;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			extSyncBit <= LINK_CONTROL_RESET[EXT_SYNC_BIT];
		end else if (writeLow) begin
			extSyncBit <= cfgReq.writeData[EXT_SYNC_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sharedRefclkBit <= LINK_CONTROL_RESET[SHARED_REFCLK_BIT];
		end else if (writeLow) begin
			sharedRefclkBit <= cfgReq.writeData[SHARED_REFCLK_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			linkOffBit <= LINK_CONTROL_RESET[LINK_OFF_BIT];
		end else if (writeLow) begin
			linkOffBit <= cfgReq.writeData[LINK_OFF_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			apmField <= LINK_CONTROL_RESET[APM_LSB +: 2];
		end else if (writeLow) begin
			apmField <= cfgReq.writeData[APM_LSB +: 2];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			retrainStart <= 1'b0;
		end else begin
			retrainStart <= writeLow && cfgReq.writeData[RETRAIN_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfgReadValid <= 1'b0;
		end else begin
			cfgReadValid <= readHit;
		end
	end

	// data bus rests at zero between answers
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfgReadData <= 32'h0000_0000;
		end else if (readHit) begin
			cfgReadData <= {16'h0000, readView};
		end else begin
			cfgReadData <= 32'h0000_0000;
		end
	end

	// control copies lag the stored image by one clock
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlExtSync <= 1'b0;
		end else begin
			ctrlExtSync <= extSyncBit;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlSharedRefclk <= 1'b0;
		end else begin
			ctrlSharedRefclk <= sharedRefclkBit;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlLinkOff <= 1'b0;
		end else begin
			ctrlLinkOff <= linkOffBit;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlApm <= LNKCTL_APM_DISABLED;
		end else begin
			ctrlApm <= lnkctl_apm_t'(apmField);
		end
	end

	// power state field reaches link logic as ctrl.apmCtrl, like the other controls
	always_comb begin
		ctrl.extSync      = ctrlExtSync;
		ctrl.sharedRefclk = ctrlSharedRefclk;
		ctrl.linkOff      = ctrlLinkOff;
		ctrl.apmCtrl      = ctrlApm;
	end

	lnkctl_latency u_latency (
		.extSync      (linkControl[EXT_SYNC_BIT]),
		.sharedRefclk (linkControl[SHARED_REFCLK_BIT]),
		.train        (next_train)
	);

	always_ff @(posedge mclk) begin
		if (rst) begin
			trainFts <= 16'h0000;
		end else begin
			trainFts <= next_train.ftsCount;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			trainSkp <= 1'b0;
		end else begin
			trainSkp <= next_train.skpAfterFts;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			trainTs1 <= 16'h0000;
		end else begin
			trainTs1 <= next_train.ts1Count;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			trainL0sLat <= 3'h0;
		end else begin
			trainL0sLat <= next_train.l0sExitLat;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			trainL1Lat <= 3'h0;
		end else begin
			trainL1Lat <= next_train.l1ExitLat;
		end
	end

	// counts and latencies handed out together
	always_comb begin
		train.ftsCount    = trainFts;
		train.skpAfterFts = trainSkp;
		train.ts1Count    = trainTs1;
		train.l0sExitLat  = trainL0sLat;
		train.l1ExitLat   = trainL1Lat;
	end
endmodule

//--- testbench/lnkctl_link_partner.sv
// link partner model: counts retrain requests reaching the link
`timescale 1ns/100ps
module lnkctl_link_partner (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       retrainStart,
	output      logic [7:0] retrainCount
);
	always_ff @(posedge mclk) begin
		if (rst) begin
			retrainCount <= 8'h00;
		end else if (retrainStart) begin
			retrainCount <= retrainCount + 8'h01;
		end
	end
endmodule

//--- testbench/lnkctl_regs_asserts.sv
// checker: port assertions for the link control register
`timescale 1ns/100ps
module lnkctl_regs_asserts #(
	parameter logic [7:0] PORT_DEVICE    = 8'h02,
	parameter logic       COMBINED_UPPER = 1'b0
) (
	input wire logic                        mclk,
	input wire logic                        rst,
	input wire lnkctl_pkg::lnkctl_cfg_req_t cfgReq,
	input wire logic                        combineActive,
	input wire logic                        cfgReadValid,
	input wire logic [31:0]                 cfgReadData,
	input wire lnkctl_pkg::lnkctl_ctrl_t    ctrl,
	input wire logic                        retrainStart,
	input wire lnkctl_pkg::lnkctl_train_t   train
);
	import lnkctl_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire hit = cfgReq.valid && cfgReq.device == PORT_DEVICE && cfgReq.function_num == 3'h0
		&& cfgReq.offset == LINK_CONTROL_OFFSET && !(COMBINED_UPPER && combineActive);
	wire wr = hit && cfgReq.write && cfgReq.byteEnable[0];
	chk_read_answer: assert property (hit && !cfgReq.write |=> cfgReadValid)
		else $error("read not answered");
	chk_no_stray: assert property (!(hit && !cfgReq.write) |=> !cfgReadValid)
		else $error("stray read answer");
	chk_rsvd_zero: assert property (cfgReadData[31:8] == 24'h0 && !cfgReadData[2])
		else $error("reserved bits set");
	chk_retrain_zero: assert property (!cfgReadData[5])
		else $error("retrain bit read as one");
	chk_boundary_zero: assert property (!cfgReadData[3])
		else $error("boundary bit set");
	chk_retrain_pulse: assert property (wr && cfgReq.writeData[5] |=> retrainStart)
		else $error("retrain pulse missing");
	chk_ctrl_update: assert property (wr |-> ##2 ctrl == {$past(cfgReq.writeData[7:6], 2),
		$past(cfgReq.writeData[4], 2), $past(cfgReq.writeData[1:0], 2)}) else $error("ctrl mismatch");
	chk_sync_counts: assert property (train.ftsCount == (ctrl.extSync ? FTS_EXT_COUNT : 16'h0)
		&& train.ts1Count == (ctrl.extSync ? TS1_EXT_COUNT : 16'h0)) else $error("count mismatch");
	chk_skp_follow: assert property (train.skpAfterFts == ctrl.extSync)
		else $error("skip set flag mismatch");
endmodule
bind lnkctl_regs lnkctl_regs_asserts #(.PORT_DEVICE(PORT_DEVICE), .COMBINED_UPPER(COMBINED_UPPER))
	chk_u (.mclk, .rst, .cfgReq, .combineActive, .cfgReadValid, .cfgReadData,
	.ctrl, .retrainStart, .train);

//--- testbench/test_lnkctl_regs.sv
// testbench: register rows, refusal and reset cases
`timescale 1ns/100ps
module test_lnkctl_regs;
	import lnkctl_pkg::*;
	logic            mclk = 1'b0;
	logic            rst = 1'b1;
	lnkctl_cfg_req_t cfgReq = '0;
	logic            combineActive = 1'b0;
	logic            cfgReadValid;
	logic [31:0]     cfgReadData;
	lnkctl_ctrl_t    ctrl;
	logic            retrainStart;
	lnkctl_train_t   train;
	logic [7:0]      retrainCount;
	int              err_count = 0;
	int              n_compared = 0;
	// write value beside read value; link off is cleared by a write of zero like any stored bit
	logic [31:0] rows [7] = '{32'h0080_0080, 32'h0041_0041, 32'h0003_0003, 32'h0000_0000,
		32'h0012_0012, 32'h00F3_00D3, 32'hFFFF_00D3};
	always #12.5 mclk = ~mclk;
	// dut acts as the upper port of a pair so its step-aside can be seen
	lnkctl_regs #(.COMBINED_UPPER(1'b1)) dut_u (.mclk, .rst, .cfgReq, .combineActive,
		.cfgReadValid, .cfgReadData, .ctrl, .retrainStart, .train);
	lnkctl_link_partner peer_u (.mclk, .rst, .retrainStart, .retrainCount);
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic req(input logic w, input logic [15:0] d, input logic [7:0] dv);
		@(posedge mclk);
		#2 cfgReq <= '{1'b1, w, dv, 3'h0, 12'h07C, 4'hF, {16'h0, d}};
		@(posedge mclk);
		#2 cfgReq.valid <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		#2 rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			req(1'b1, rows[i][31:16], PORT_LOW_ID);
			req(1'b0, 16'h0, PORT_LOW_ID);
			chk({cfgReadValid, cfgReadData}, {1'b1, 16'h0000, rows[i][15:0]});
		end
		req(1'b0, 16'h0, 8'h03);
		chk({cfgReadValid, cfgReadData}, 33'h0);
		chk({25'h0, retrainCount}, 33'h2);
		chk({17'h0, train.ftsCount}, {17'h0, FTS_EXT_COUNT});
		chk({17'h0, train.ts1Count}, {17'h0, TS1_EXT_COUNT});
		combineActive <= 1'b1;
		req(1'b1, 16'h0092, PORT_LOW_ID);
		req(1'b0, 16'h0, PORT_LOW_ID);
		chk({cfgReadValid, cfgReadData}, 33'h0);
		combineActive <= 1'b0;
		req(1'b0, 16'h0, PORT_LOW_ID);
		chk({cfgReadValid, cfgReadData}, {1'b1, 16'h0000, 16'h00D3});
		@(posedge mclk);
		#2 rst <= 1'b1;
		repeat (2) @(posedge mclk);
		#2 rst <= 1'b0;
		req(1'b0, 16'h0, PORT_LOW_ID);
		chk({cfgReadValid, cfgReadData}, {1'b1, 16'h0000, 16'h0000});
		chk({28'h0, ctrl}, 33'h0);
		chk({17'h0, train.ftsCount}, {17'h0, FTS_NORMAL_COUNT});
		chk({17'h0, train.ts1Count}, {17'h0, TS1_NORMAL_COUNT});
		tally_and_finish;
	end
	initial begin
		#50000;
		err_count++;
		tally_and_finish;
	end
endmodule
